// ---- dv/matrix_point_stepper_tb_top.sv ----
// Testbench: walks the matrix point stepper through its sequencer model.
// Assumes design, checker and model are compiled first.
`timescale 1ns/1ps
`include "mps_defines.svh"
module matrix_point_stepper_tb_top;
  import mps_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid, cmd_ready, cmd_ack, loop_end, move_valid, param_error;
  mps_cmd_t cmd_op;
  logic [`MPS_GRP_W:0] group_index;
  mps_group_t cmd_cfg;
  logic [2:0] blank_set;
  mps_dest_t move_dest;
  logic [7:0] error_code;
  logic [`MPS_TBL_W-1:0] lk_origin, lk_end1, lk_end2;
  int n_fail = 0;
  int samples_checked = 0;
  // Origin above both ends on purpose: placement is free
  mps_group_t grid = '{10'h3E7, 10'h000, 10'h002, 14'h0003, 14'h0002, 7'h01, 7'h02};
  mps_group_t row = '{10'h010, 10'h011, 10'h000, 14'h0003, 14'h0000, 7'h63, 7'h05};
  always #5 clk_sys = ~clk_sys;
  mps_top i_mps_top (.clk_sys, .rstn, .cmd_valid, .cmd_op, .group_index, .cmd_cfg,
    .origin_blank(blank_set[2]), .end1_blank(blank_set[1]), .end2_blank(blank_set[0]),
    .cmd_ready, .cmd_ack, .loop_end, .move_valid, .move_dest, .param_error, .error_code,
    .lookup_origin_no(lk_origin), .lookup_end1_no(lk_end1), .lookup_end2_no(lk_end2));
  mps_seq_model i_mps_seq_model (.clk_sys, .cmd_ready, .cmd_ack, .cmd_op, .cmd_valid,
    .group_index, .cmd_cfg, .blank_set);
  task automatic end_sim;
    $display("checked %0d mismatched %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic run(input mps_cmd_t op, input logic [5:0] g, input mps_group_t c,
      input logic [2:0] b);
    logic ok;
    i_mps_seq_model.issue(op, g, c, b, ok);
    cmp("ack", 32'h1, {31'h0, ok});
    if (!ok) end_sim();
  endtask
  function automatic logic [31:0] pt(input int c1, input int c2, input int n1);
    return {4'h1, 28'(c1 + n1 * (c2 - 1))};
  endfunction
  task automatic t_refuse;
    mps_group_t bad[3];
    bad = '{grid, grid, grid};
    bad[0].count1 = 14'h2710;
    bad[1].end1_no = 10'h3E8;
    bad[2].ctr2_no = 7'h64;
    run(MPS_CMD_INIT, 6'h00, grid, 3'b000);
    cmp("group 0", 32'h1A9, {param_error, error_code});
    run(MPS_CMD_LOOP, 6'h21, grid, 3'b000);
    cmp("group 33", 32'h1A9, {param_error, error_code});
    foreach (bad[k]) begin
      run(MPS_CMD_CFG, 6'h02, bad[k], 3'b000);
      cmp("range", 32'h1A9, {param_error, error_code});
    end
  endtask
  task automatic walk(input logic [5:0] g, input mps_group_t c, input logic [2:0] b);
    int c1, c2;
    logic fin;
    c1 = 1;
    c2 = 1;
    fin = 1'b0;
    run(MPS_CMD_CFG, g, c, 3'b000);
    run(MPS_CMD_INIT, g, c, 3'b000);
    for (int k = 0; k < 40 && !fin; k++) begin
      run(MPS_CMD_MOVE, g, c, b);
      cmp("point", pt(c1, c2, c.count1), {3'h0, move_valid, move_dest.point_index});
      cmp("numbers", {c.origin_no, c.end1_no, c.end2_no}, move_dest[29:0]);
      cmp("lookup", {c.origin_no, c.end1_no, c.end2_no}, {lk_origin, lk_end1, lk_end2});
      fin = c1 >= c.count1 && (c.count2 == 0 || c2 >= c.count2);
      run(MPS_CMD_LOOP, g, c, 3'b000);
      cmp("loop end", {31'h0, fin}, {31'h0, loop_end});
      if (!fin) begin
        c1++;
        if (c1 > c.count1) begin
          c1 = 1;
          c2++;
        end
      end
    end
    run(MPS_CMD_MOVE, g, c, b);
    cmp("end point", pt(c1, c2, c.count1), {3'h0, move_valid, move_dest.point_index});
  endtask
  task automatic t_blank;
    for (int k = 0; k < 3; k++) begin
      run(MPS_CMD_MOVE, 6'h01, grid, 3'b100 >> k);
      cmp("blank", 32'h1A8, {move_valid, param_error, error_code});
    end
    run(MPS_CMD_INIT, 6'h01, grid, 3'b000);
    run(MPS_CMD_MOVE, 6'h01, grid, 3'b000);
    cmp("after init", pt(1, 1, 3), {3'h0, move_valid, move_dest.point_index});
    cmp("error clear", 32'h0, {param_error, error_code});
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    cmp("reset", 32'h0, {29'h0, cmd_ready, cmd_ack, param_error});
    @(negedge clk_sys);
    rstn = 1'b1;
    t_refuse();
    walk(6'h01, grid, 3'b000);
    t_blank();
    walk(6'h20, row, 3'b001);
    end_sim();
  end
endmodule

// ---- dv/mps_seq_model.sv ----
// Sequencer model: issues one matrix command at a time, waits for the answer.
// Assumes answers settle before the falling edge of clk_sys.
`timescale 1ns/1ps
`include "mps_defines.svh"
module mps_seq_model
  import mps_pkg::*;
(
  // Clock and answers
  input wire logic clk_sys,
  input wire logic cmd_ready,
  input wire logic cmd_ack,
  // Command and table status
  output mps_cmd_t cmd_op,
  output logic cmd_valid,
  output logic [`MPS_GRP_W:0] group_index,
  output mps_group_t cmd_cfg,
  output logic [2:0] blank_set
);
  initial begin
    cmd_valid = 1'b0;
    cmd_op = MPS_CMD_INIT;
    group_index = '0;
    cmd_cfg = '0;
    blank_set = '0;
  end
  // Group index and config are inverted once taken, so a late read by the block shows up
  task automatic issue(input mps_cmd_t op, input logic [`MPS_GRP_W:0] g,
      input mps_group_t c, input logic [2:0] b, output logic ok);
    ok = 1'b0;
    @(negedge clk_sys);
    cmd_op = op;
    group_index = g;
    cmd_cfg = c;
    blank_set = b;
    cmd_valid = 1'b1;
    // Ready is settled at the falling edge, so the next rising edge takes
    for (int n = 0; n < 16 && !ok; n++) begin
      ok = cmd_ready;
      @(negedge clk_sys);
    end
    cmd_valid = 1'b0;
    group_index = ~g;
    cmd_cfg = ~c;
    for (int n = 0; n < 4 && ok && !cmd_ack; n++) @(negedge clk_sys);
    ok = ok && cmd_ack;
  endtask
endmodule

// ---- dv/mps_top_chk.sv ----
// Port-level properties of the matrix point stepper.
// Assumes a bind onto mps_top and a single clock domain.
`timescale 1ns/1ps
`include "mps_defines.svh"
module mps_top_chk
  import mps_pkg::*;
#(parameter int GROUPS = `MPS_GROUPS) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Command
  input wire logic cmd_valid,
  input wire mps_cmd_t cmd_op,
  input wire logic [`MPS_GRP_W:0] group_index,
  input wire mps_group_t cmd_cfg,
  input wire logic origin_blank,
  // Answers
  input wire logic cmd_ready,
  input wire logic cmd_ack,
  input wire logic loop_end,
  input wire logic move_valid,
  input wire mps_dest_t move_dest,
  input wire logic param_error,
  input wire logic [7:0] error_code
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire logic take = cmd_valid && cmd_ready;
  wire logic grp_ok = group_index != 0 && group_index <= GROUPS;
  wire logic [8:0] err = {param_error, error_code};
  property p_ack_once; cmd_ack |=> !cmd_ack && cmd_ready; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack not single");
  property p_take; take |=> !cmd_ready ##[0:1] cmd_ack; endproperty
  a_take: assert property (p_take) else $error("take without ack");
  property p_busy; cmd_ack |-> !cmd_ready; endproperty
  a_busy: assert property (p_busy) else $error("ready during ack");
  property p_loop; loop_end |-> cmd_ack && !move_valid && !param_error; endproperty
  a_loop: assert property (p_loop) else $error("stray loop end");
  property p_move; move_valid |-> cmd_ack && !param_error && move_dest.point_index != 0; endproperty
  a_move: assert property (p_move) else $error("bad move answer");
  property p_grp; take && !grp_ok |=> cmd_ack && err == {1'b1, `MPS_ERR_RANGE}; endproperty
  a_grp: assert property (p_grp) else $error("bad group accepted");
  property p_cnt;
    take && grp_ok && cmd_op == MPS_CMD_CFG && cmd_cfg.count1 > `MPS_CNT_MAX
      |=> cmd_ack && err == {1'b1, `MPS_ERR_RANGE};
  endproperty
  a_cnt: assert property (p_cnt) else $error("count range accepted");
  property p_blank;
    take && grp_ok && cmd_op == MPS_CMD_MOVE ##1 origin_blank
      |=> cmd_ack && !move_valid && err == {1'b1, `MPS_ERR_CODE};
  endproperty
  a_blank: assert property (p_blank) else $error("blank entry moved");
  property p_init;
    take && grp_ok && cmd_op == MPS_CMD_INIT |-> ##2 cmd_ack && !loop_end && !err[8];
  endproperty
  a_init: assert property (p_init) else $error("init answer wrong");
  c_end: cover property (loop_end);
  c_move: cover property (move_valid);
  c_blank: cover property (err == {1'b1, `MPS_ERR_CODE});
endmodule
bind mps_top mps_top_chk #(.GROUPS(GROUPS)) i_mps_top_chk (.clk_sys, .rstn, .cmd_valid,
  .cmd_op, .group_index, .cmd_cfg, .origin_blank, .cmd_ready, .cmd_ack, .loop_end,
  .move_valid, .move_dest, .param_error, .error_code);

// ---- hw/mps_counter_bank.sv ----
// Direction counters, 100 of them, shared by all groups as in a counter table.
// Assumes at most one write per port per cycle.
`timescale 1ns/1ps
`include "mps_defines.svh"
module mps_counter_bank #(
  parameter int COUNTERS = `MPS_COUNTERS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Two write ports, port b wins on the same index
  input wire logic wa_en,
  input wire logic [`MPS_CTR_W-1:0] wa_idx,
  input wire logic [`MPS_CNT_W-1:0] wa_val,
  input wire logic wb_en,
  input wire logic [`MPS_CTR_W-1:0] wb_idx,
  input wire logic [`MPS_CNT_W-1:0] wb_val,
  // Read ports
  input wire logic [`MPS_CTR_W-1:0] ra_idx,
  input wire logic [`MPS_CTR_W-1:0] rb_idx,
  output logic [`MPS_CNT_W-1:0] ra_val,
  output logic [`MPS_CNT_W-1:0] rb_val
);
  logic [`MPS_CNT_W-1:0] ctr_ff [COUNTERS];
  genvar c;
  generate
    for (c = 0; c < COUNTERS; c++) begin : g_ctr
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          ctr_ff[c] <= `MPS_ONE;
        end else if (wb_en && wb_idx == `MPS_CTR_W'(c)) begin
          ctr_ff[c] <= wb_val;
        end else if (wa_en && wa_idx == `MPS_CTR_W'(c)) begin
          ctr_ff[c] <= wa_val;
        end
      end
    end
  endgenerate
  assign ra_val = ctr_ff[ra_idx];
  assign rb_val = ctr_ff[rb_idx];
endmodule

// ---- hw/mps_defines.svh ----
// Constants for the matrix point stepper: field widths, limits and codes.
// Assumes inclusion by bare name from the package and modules.
`ifndef MPS_DEFINES_SVH
`define MPS_DEFINES_SVH
`define MPS_GROUPS 32
`define MPS_GRP_W 5
`define MPS_TBL_W 10
`define MPS_TBL_MAX 10'h3E7
`define MPS_CNT_W 14
`define MPS_CNT_MAX 14'h270F
`define MPS_CTR_W 7
`define MPS_CTR_MAX 7'h63
`define MPS_COUNTERS 100
`define MPS_IDX_W 28
`define MPS_ONE 14'h0001
`define MPS_ERR_CODE 8'hA8
`define MPS_ERR_NONE 8'h00
`define MPS_ERR_RANGE 8'hA9
`endif

// ---- hw/mps_group_store.sv ----
// Group description storage: 32 entries of flip-flops, one write port.
// Assumes writes are already range checked by the caller.
`timescale 1ns/1ps
`include "mps_defines.svh"
module mps_group_store
  import mps_pkg::*;
#(
  parameter int GROUPS = `MPS_GROUPS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Write port
  input wire logic wr_en,
  input wire logic [`MPS_GRP_W-1:0] wr_idx,
  input wire mps_group_t wr_data,
  // Read port
  input wire logic [`MPS_GRP_W-1:0] rd_idx,
  output mps_group_t rd_data
);
  mps_group_t mem_ff [GROUPS];
  genvar g;
  generate
    for (g = 0; g < GROUPS; g++) begin : g_ent
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          mem_ff[g] <= '0;
        end else if (wr_en && wr_idx == `MPS_GRP_W'(g)) begin
          mem_ff[g] <= wr_data;
        end
      end
    end
  endgenerate
  assign rd_data = mem_ff[rd_idx];
endmodule

// ---- hw/mps_pkg.sv ----
// Types shared by the matrix point stepper modules.
// Assumes mps_defines.svh sits on the include path.
`include "mps_defines.svh"
package mps_pkg;
  typedef struct packed {
    logic [`MPS_TBL_W-1:0] origin_no;
    logic [`MPS_TBL_W-1:0] end1_no;
    logic [`MPS_TBL_W-1:0] end2_no;
    logic [`MPS_CNT_W-1:0] count1;
    logic [`MPS_CNT_W-1:0] count2;
    logic [`MPS_CTR_W-1:0] ctr1_no;
    logic [`MPS_CTR_W-1:0] ctr2_no;
  } mps_group_t;
  typedef enum logic [1:0] {
    MPS_CMD_INIT = 2'h0,
    MPS_CMD_MOVE = 2'h1,
    MPS_CMD_LOOP = 2'h2,
    MPS_CMD_CFG = 2'h3
  } mps_cmd_t;
  typedef struct packed {
    logic [`MPS_IDX_W-1:0] point_index;
    logic [`MPS_TBL_W-1:0] origin_no;
    logic [`MPS_TBL_W-1:0] end1_no;
    logic [`MPS_TBL_W-1:0] end2_no;
  } mps_dest_t;
endpackage

// ---- hw/mps_top.sv ----
// Matrix point stepper: group table, counter init, move point and loop step.
// Assumes the sequencer holds cmd fields stable while cmd_valid is high
// and that a coordinate table outside answers blank status combinationally.
// How it works
// - Thirty-two groups selected by index one upward
// - Groups hold table numbers, not coordinates
// - Table numbers limited to zero through 999
// - Blank origin or end1 entry on move raises error, end2 only if count2 nonzero
// - Item counts limited to zero through 9999
// - Counter numbers limited to zero through 99
// - Origin placement free; order follows points
// - Point index is c1 plus n1 times c2-1
// - Init sets both group counters to one
// - Loop steps first counter, wraps into second
// - Loop reports end when counts reached
`timescale 1ns/1ps
`include "mps_defines.svh"
module mps_top
  import mps_pkg::*;
#(
  parameter int GROUPS = `MPS_GROUPS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Command from sequencer
  input wire logic cmd_valid,
  input wire mps_cmd_t cmd_op,
  input wire logic [`MPS_GRP_W:0] group_index,
  input wire mps_group_t cmd_cfg,
  // Coordinate table blank status for the three referenced numbers
  input wire logic origin_blank,
  input wire logic end1_blank,
  input wire logic end2_blank,
  // Answers
  output logic cmd_ready,
  output logic cmd_ack,
  output logic loop_end,
  output logic move_valid,
  output mps_dest_t move_dest,
  output logic param_error,
  output logic [7:0] error_code,
  // Table numbers being looked up in the coordinate table
  output logic [`MPS_TBL_W-1:0] lookup_origin_no,
  output logic [`MPS_TBL_W-1:0] lookup_end1_no,
  output logic [`MPS_TBL_W-1:0] lookup_end2_no
);
  typedef enum logic [2:0] {
    MPS_IDLE = 3'b001,
    MPS_EXEC = 3'b010,
    MPS_DONE = 3'b100
  } mps_state_t;

  mps_state_t state_ff, nxt_state;
  mps_cmd_t op_ff;
  logic [`MPS_GRP_W-1:0] grp_ff;
  logic cmd_ready_ff, cmd_ack_ff, loop_end_ff, move_valid_ff, param_error_ff;
  logic [7:0] error_code_ff;
  mps_dest_t move_dest_ff;
  mps_group_t cfg_ff;

  // Group index 1..32 maps to entry 0..31; zero or above range is refused
  logic idx_ok;
  logic [`MPS_GRP_W:0] idx_m1;
  assign idx_m1 = group_index - 6'h01;
  assign idx_ok = (group_index != 6'h00) && (group_index <= 6'(GROUPS));

  // Range check on configuration values
  logic cfg_ok;
  assign cfg_ok = (cmd_cfg.origin_no <= `MPS_TBL_MAX) && (cmd_cfg.end1_no <= `MPS_TBL_MAX) &&
                  (cmd_cfg.end2_no <= `MPS_TBL_MAX) &&
                  (cmd_cfg.count1 <= `MPS_CNT_MAX) && (cmd_cfg.count2 <= `MPS_CNT_MAX) &&
                  (cmd_cfg.ctr1_no <= `MPS_CTR_MAX) && (cmd_cfg.ctr2_no <= `MPS_CTR_MAX);

  logic take;
  // Ready gates the take: a command held across reset release waits for ready
  assign take = (state_ff == MPS_IDLE) && cmd_ready_ff && cmd_valid;

  logic cmd_good;
  assign cmd_good = idx_ok && ((cmd_op != MPS_CMD_CFG) || cfg_ok);

  // Group storage
  mps_group_t grp_rd;
  logic store_wr;
  assign store_wr = take && cmd_good && (cmd_op == MPS_CMD_CFG);
  mps_group_store #(.GROUPS(GROUPS)) u_store (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .wr_en(store_wr),
    .wr_idx(idx_m1[`MPS_GRP_W-1:0]),
    .wr_data(cmd_cfg),
    .rd_idx(grp_ff),
    .rd_data(grp_rd)
  );

  // Counter bank and its update logic
  logic [`MPS_CNT_W-1:0] c1, c2;
  logic ctr_wa, ctr_wb;
  logic [`MPS_CNT_W-1:0] wa_val, wb_val;
  logic exec_now;
  assign exec_now = (state_ff == MPS_EXEC);

  logic first_wrap, at_end, c1_reached, c2_reached;
  // With a zero second count the grid is a single row
  assign c1_reached = (c1 >= grp_rd.count1);
  assign c2_reached = (grp_rd.count2 == 14'h0000) || (c2 >= grp_rd.count2);
  assign at_end = c1_reached && c2_reached;
  assign first_wrap = c1_reached;

  logic is_init, is_loop;
  assign is_init = exec_now && (op_ff == MPS_CMD_INIT);
  assign is_loop = exec_now && (op_ff == MPS_CMD_LOOP) && !at_end;

  // Init writes both to one; loop steps c1 or wraps it and steps c2
  assign ctr_wa = is_init || is_loop;
  assign wa_val = (is_init || first_wrap) ? `MPS_ONE : 14'(c1 + `MPS_ONE);
  assign ctr_wb = is_init || (is_loop && first_wrap);
  assign wb_val = is_init ? `MPS_ONE : 14'(c2 + `MPS_ONE);

  mps_counter_bank u_ctr (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .wa_en(ctr_wa),
    .wa_idx(grp_rd.ctr1_no),
    .wa_val(wa_val),
    .wb_en(ctr_wb),
    .wb_idx(grp_rd.ctr2_no),
    .wb_val(wb_val),
    .ra_idx(grp_rd.ctr1_no),
    .rb_idx(grp_rd.ctr2_no),
    .ra_val(c1),
    .rb_val(c2)
  );

  // Destination index from counters only; origin order is whatever the points say
  logic [`MPS_IDX_W-1:0] point_idx;
  logic [`MPS_CNT_W-1:0] c2_m1;
  assign c2_m1 = (c2 == 14'h0000) ? 14'h0000 : 14'(c2 - `MPS_ONE);
  assign point_idx = `MPS_IDX_W'(c1) + `MPS_IDX_W'(grp_rd.count1) * `MPS_IDX_W'(c2_m1);

  logic any_blank, is_move;
  assign is_move = exec_now && (op_ff == MPS_CMD_MOVE);
  // Second end is unused in a single row, so its blank state is ignored then
  assign any_blank = origin_blank || end1_blank ||
                     (end2_blank && grp_rd.count2 != 14'h0000);

  mps_dest_t nxt_dest;
  assign nxt_dest.point_index = point_idx;
  assign nxt_dest.origin_no = grp_rd.origin_no;
  assign nxt_dest.end1_no = grp_rd.end1_no;
  assign nxt_dest.end2_no = grp_rd.end2_no;

  // State machine: IDLE takes, EXEC updates, DONE acks and re-arms
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      MPS_IDLE: begin
        if (take && cmd_good && cmd_op != MPS_CMD_CFG) begin
          nxt_state = MPS_EXEC;
        end else if (take) begin
          nxt_state = MPS_DONE;
        end
      end
      MPS_EXEC: begin
        nxt_state = MPS_DONE;
      end
      MPS_DONE: begin
        nxt_state = MPS_IDLE;
      end
      default: begin
        nxt_state = MPS_IDLE;
      end
    endcase
  end

  logic nxt_ack, nxt_loop_end, nxt_move_valid, nxt_err;
  logic [7:0] nxt_code;
  assign nxt_ack = exec_now || (take && !(cmd_good && cmd_op != MPS_CMD_CFG));
  assign nxt_loop_end = exec_now && (op_ff == MPS_CMD_LOOP) && at_end;
  assign nxt_move_valid = is_move && !any_blank;
  assign nxt_err = (is_move && any_blank) || (take && !cmd_good);
  assign nxt_code = (is_move && any_blank) ? `MPS_ERR_CODE :
                    (take && !cmd_good) ? `MPS_ERR_RANGE : `MPS_ERR_NONE;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff <= MPS_IDLE;
      op_ff <= MPS_CMD_INIT;
      grp_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (take) begin
        op_ff <= cmd_op;
        grp_ff <= idx_m1[`MPS_GRP_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cmd_ready_ff <= 1'b0;
      cmd_ack_ff <= 1'b0;
      loop_end_ff <= 1'b0;
      move_valid_ff <= 1'b0;
    end else begin
      cmd_ready_ff <= (nxt_state == MPS_IDLE);
      cmd_ack_ff <= nxt_ack;
      loop_end_ff <= nxt_loop_end;
      move_valid_ff <= nxt_move_valid;
    end
  end

  // Error stays up until the next accepted command; a new error wins over the clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      param_error_ff <= 1'b0;
      error_code_ff <= `MPS_ERR_NONE;
    end else if (nxt_err) begin
      param_error_ff <= 1'b1;
      error_code_ff <= nxt_code;
    end else if (take) begin
      param_error_ff <= 1'b0;
      error_code_ff <= `MPS_ERR_NONE;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      move_dest_ff <= '0;
      cfg_ff <= '0;
    end else begin
      if (nxt_move_valid) begin
        move_dest_ff <= nxt_dest;
      end
      if (exec_now) begin
        cfg_ff <= grp_rd;
      end
    end
  end

  assign cmd_ready = cmd_ready_ff;
  assign cmd_ack = cmd_ack_ff;
  assign loop_end = loop_end_ff;
  assign move_valid = move_valid_ff;
  assign move_dest = move_dest_ff;
  assign param_error = param_error_ff;
  assign error_code = error_code_ff;
  assign lookup_origin_no = cfg_ff.origin_no;
  assign lookup_end1_no = cfg_ff.end1_no;
  assign lookup_end2_no = cfg_ff.end2_no;
endmodule
